/* File: logic/efic_pkg.sv */
// Purpose: Shared constants for the fault flag and interrupt command unit.
// Assumes: Commands reach the unit as nine-byte binary frames.
// Notes: Register offsets are word indices on the plain register port.
package efic_pkg;
    localparam int DATA_W = 32;
    localparam int FLG_W  = 8;
    localparam int ADDR_W = 4;
    localparam int N_SRC  = 16;
    localparam int SRC_W  = 4;
    localparam int N_FLT  = 5;
    localparam int N_ST   = 5;

    localparam logic [3:0] FRAME_LAST = 4'h8;

    localparam logic [7:0] CMD_CLE     = 8'h24;
    localparam logic [7:0] CMD_IRQ_EN  = 8'h19;
    localparam logic [7:0] CMD_IRQ_DIS = 8'h1A;
    localparam logic [7:0] CMD_VEC_DEF = 8'h25;
    localparam logic [7:0] CMD_IRQ_RET = 8'h26;

    localparam logic [7:0] TYP_ALL     = 8'h00;
    localparam logic [7:0] TYP_TIMEOUT = 8'h01;
    localparam logic [7:0] TYP_GLOBAL  = 8'hFF;

    localparam logic [ADDR_W-1:0] REG_STAT  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MASK  = 4'h1;
    localparam logic [ADDR_W-1:0] REG_FAULT = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CTRL  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_SRCEN = 4'h4;
    localparam logic [ADDR_W-1:0] REG_NODE  = 4'h5;

    localparam int ST_FRAME  = 0;
    localparam int ST_CKERR  = 1;
    localparam int ST_ENTER  = 2;
    localparam int ST_RETURN = 3;
    localparam int ST_FAULT  = 4;

    localparam logic [7:0] NODE_RST = 8'h01;

    typedef enum logic {
        MODE_RUN,
        MODE_HANDLER
    } efic_mode_e;
endpackage

/* File: logic/efic_cmd_if.sv */
// Purpose: Carries one decoded command from the frame receiver to the executor.
// Assumes: valid is a one-cycle pulse; the fields stand while valid is high.
// Notes: None.
interface efic_cmd_if;
    logic        valid;
    logic [7:0]  instr;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
    modport src (output valid, output instr, output typ, output bank, output value);
    modport dst (input valid, input instr, input typ, input bank, input value);
endinterface

/* File: logic/efic_frame_rx.sv */
// Purpose: Assembles nine-byte command frames and checks their checksum.
// Assumes: Bytes come from logic on the same clock, one per valid cycle.
// Notes: A frame for another node with a good checksum is dropped silently, without an error.
module efic_frame_rx
    import efic_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] byte_in,
    input  wire logic       byte_valid,
    input  wire logic [7:0] node_addr,
    efic_cmd_if.src         cmd,
    output logic            ck_err
);
    logic [3:0]  cnt_q;
    logic [7:0]  sum_q;
    logic [7:0]  addr_q;
    logic [7:0]  instr_q;
    logic [7:0]  typ_q;
    logic [7:0]  bank_q;
    logic [31:0] value_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (byte_valid) begin
            cnt_q <= (cnt_q == FRAME_LAST) ? 4'h0 : cnt_q + 4'h1;
            sum_q <= (cnt_q == FRAME_LAST) ? 8'h00 : sum_q + byte_in;
        end
    end

    // Field order: address, instruction, type, bank, value MSB first, checksum.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_q  <= 8'h00;
            instr_q <= 8'h00;
            typ_q   <= 8'h00;
            bank_q  <= 8'h00;
            value_q <= 32'h0;
        end else if (byte_valid) begin
            case (cnt_q)
                4'h0: addr_q <= byte_in;
                4'h1: instr_q <= byte_in;
                4'h2: typ_q <= byte_in;
                4'h3: bank_q <= byte_in;
                4'h4, 4'h5, 4'h6, 4'h7: value_q <= {value_q[23:0], byte_in};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd.valid <= 1'b0;
            cmd.instr <= 8'h00;
            cmd.typ   <= 8'h00;
            cmd.bank  <= 8'h00;
            cmd.value <= 32'h0;
            ck_err    <= 1'b0;
        end else begin
            cmd.valid <= 1'b0;
            ck_err    <= 1'b0;
            if (byte_valid && cnt_q == FRAME_LAST) begin
                if (byte_in != sum_q) begin
                    ck_err <= 1'b1;
                end else if (addr_q == node_addr) begin
                    cmd.valid <= 1'b1;
                    cmd.instr <= instr_q;
                    cmd.typ   <= typ_q;
                    cmd.bank  <= bank_q;
                    cmd.value <= value_q;
                end
            end
        end
    end

    ck_bad_a: assert property (@(posedge clk) disable iff (!rstn)
        byte_valid && cnt_q == FRAME_LAST && byte_in != sum_q |=> !cmd.valid && ck_err)
        else $error("Frame with bad checksum was not rejected.");
endmodule

/* File: logic/efic_vec_tbl.sv */
// Purpose: Holds one handler entry address for each interrupt source.
// Assumes: Writes come from the vector definition command only.
// Notes: Reads are combinational so the entry address is ready in the take cycle.
module efic_vec_tbl
    import efic_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              we,
    input  wire logic [SRC_W-1:0]  waddr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [SRC_W-1:0]  raddr,
    output logic      [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem_q [N_SRC];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N_SRC; i++) begin
                mem_q[i] <= 32'h0;
            end
        end else if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    assign rdata = mem_q[raddr];

    vec_store_a: assert property (@(posedge clk) disable iff (!rstn)
        we |=> mem_q[$past(waddr)] == $past(wdata))
        else $error("Vector write did not replace the entry address.");
endmodule

/* File: logic/efic_top.sv */
// Purpose: Clears fault flags and runs interrupt enable, vector and return commands.
// Assumes: Command bytes and context words come from logic on CLK_SYS.
// Notes: Fault and interrupt source pins are synchronised before use.
// Contract
// - A clear-fault command clears the flags chosen by its type and leaves the others.
// - Type 0 clears all flags and types 1 to 5 clear timeout, alarm, deviation, position and shutdown.
// - An enable command turns on the single source named by its type.
// - An enable command with type 255 sets the global interrupt enable instead.
// - A disable command turns off the single source named by its type.
// - A disable command with type 255 clears the global enable so no interrupt is taken.
// - A vector command stores its value as the entry address of the source named by its type.
// - A later vector command for the same source replaces the entry address.
// - A return command restores accumulator, X, flags and program counter saved at entry.
// - A frame is address, instruction, type, bank, four value bytes MSB first, checksum.
module efic_top
    import efic_pkg::*;
(
    input  wire logic                        CLK_SYS,
    input  wire logic                        RSTN,
    input  wire logic [7:0]                  RX_BYTE,
    input  wire logic                        RX_VALID,
    input  wire logic [efic_pkg::N_FLT-1:0]  FAULT_IN,
    input  wire logic [efic_pkg::N_SRC-1:0]  IRQ_SRC,
    input  wire logic [efic_pkg::DATA_W-1:0] CTX_ACC,
    input  wire logic [efic_pkg::DATA_W-1:0] CTX_X,
    input  wire logic [efic_pkg::FLG_W-1:0]  CTX_FLAGS,
    input  wire logic [efic_pkg::DATA_W-1:0] CTX_PC,
    input  wire logic [efic_pkg::ADDR_W-1:0] REG_ADDR,
    input  wire logic [efic_pkg::DATA_W-1:0] REG_WDATA,
    input  wire logic                        REG_WR,
    input  wire logic                        REG_RD,
    output logic      [efic_pkg::DATA_W-1:0] REG_RDATA,
    output logic                             IRQ,
    output logic      [efic_pkg::N_FLT-1:0]  FAULT_FLAGS,
    output logic                             IRQ_ENTER,
    output logic      [efic_pkg::DATA_W-1:0] ENTRY_PC,
    output logic                             IRQ_RESTORE,
    output logic      [efic_pkg::DATA_W-1:0] RST_ACC,
    output logic      [efic_pkg::DATA_W-1:0] RST_X,
    output logic      [efic_pkg::FLG_W-1:0]  RST_FLAGS,
    output logic      [efic_pkg::DATA_W-1:0] RST_PC
);
    import efic_pkg::*;

    function automatic logic src_ok(input logic [7:0] t);
        src_ok = t < 8'(N_SRC);
    endfunction

    efic_cmd_if cmd ();

    logic [N_FLT-1:0]  flt_s1_q;
    logic [N_FLT-1:0]  flt_s2_q;
    logic [N_SRC-1:0]  src_s1_q;
    logic [N_SRC-1:0]  src_s2_q;
    logic [N_SRC-1:0]  src_s3_q;
    logic [N_SRC-1:0]  pend_q;
    logic [N_SRC-1:0]  src_en_q;
    logic              glob_en_q;
    logic [N_FLT-1:0]  fault_q;
    logic [N_FLT-1:0]  cle_mask;
    logic [N_ST-1:0]   stat_q;
    logic [N_ST-1:0]   mask_q;
    logic [N_ST-1:0]   ev;
    logic [7:0]        node_q;
    logic              ck_err;
    logic              is_cle;
    logic              is_en;
    logic              is_dis;
    logic              is_vec;
    logic              is_ret;
    logic              take;
    logic [SRC_W-1:0]  take_idx;
    logic [N_SRC-1:0]  ready;
    logic [DATA_W-1:0] vec_rd;
    logic              ret_done;
    efic_mode_e        mode_q;

    efic_frame_rx u_rx (
        .clk        (CLK_SYS),
        .rstn       (RSTN),
        .byte_in    (RX_BYTE),
        .byte_valid (RX_VALID),
        .node_addr  (node_q),
        .cmd        (cmd.src),
        .ck_err     (ck_err)
    );

    efic_vec_tbl u_vec (
        .clk   (CLK_SYS),
        .rstn  (RSTN),
        .we    (is_vec && src_ok(cmd.typ)),
        .waddr (cmd.typ[SRC_W-1:0]),
        .wdata (cmd.value),
        .raddr (take_idx),
        .rdata (vec_rd)
    );

    // Bank and value are never decoded for the clear, enable, disable and return commands.
    assign is_cle  = cmd.valid && cmd.instr == CMD_CLE;
    assign is_en    = cmd.valid && cmd.instr == CMD_IRQ_EN;
    assign is_dis   = cmd.valid && cmd.instr == CMD_IRQ_DIS;
    assign is_vec   = cmd.valid && cmd.instr == CMD_VEC_DEF;
    assign is_ret   = cmd.valid && cmd.instr == CMD_IRQ_RET;
    assign ret_done = is_ret && mode_q == MODE_HANDLER;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            flt_s1_q <= '0;
            flt_s2_q <= '0;
            src_s1_q <= '0;
            src_s2_q <= '0;
            src_s3_q <= '0;
        end else begin
            flt_s1_q <= FAULT_IN;
            flt_s2_q <= flt_s1_q;
            src_s1_q <= IRQ_SRC;
            src_s2_q <= src_s1_q;
            src_s3_q <= src_s2_q;
        end
    end

    always_comb begin
        cle_mask = '0;
        if (is_cle) begin
            if (cmd.typ == TYP_ALL) begin
                cle_mask = '1;
            end else begin
                for (int i = 0; i < N_FLT; i++) begin
                    if (cmd.typ == 8'(i + 1)) begin
                        cle_mask[i] = 1'b1;
                    end
                end
            end
        end
    end

    // A fault still asserted on its pin wins over a clear in the same cycle.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            fault_q <= '0;
        end else begin
            fault_q <= (fault_q & ~cle_mask) | flt_s2_q;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            src_en_q  <= '0;
            glob_en_q <= 1'b0;
        end else if (is_en) begin
            if (cmd.typ == TYP_GLOBAL) begin
                glob_en_q <= 1'b1;
            end else if (src_ok(cmd.typ)) begin
                src_en_q[cmd.typ[SRC_W-1:0]] <= 1'b1;
            end
        end else if (is_dis) begin
            if (cmd.typ == TYP_GLOBAL) begin
                glob_en_q <= 1'b0;
            end else if (src_ok(cmd.typ)) begin
                src_en_q[cmd.typ[SRC_W-1:0]] <= 1'b0;
            end
        end
    end

    assign ready = pend_q & src_en_q;

    // Lowest source number has priority; one handler runs at a time.
    always_comb begin
        take_idx = '0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (ready[i]) begin
                take_idx = SRC_W'(i);
            end
        end
        take = glob_en_q && mode_q == MODE_RUN && |ready;
    end

    // A new edge on the source taken in this cycle stays pending.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pend_q <= '0;
        end else begin
            for (int i = 0; i < N_SRC; i++) begin
                if (src_s2_q[i] && !src_s3_q[i]) begin
                    pend_q[i] <= 1'b1;
                end else if (take && take_idx == SRC_W'(i)) begin
                    pend_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mode_q <= MODE_RUN;
        end else begin
            case (mode_q)
                MODE_RUN: begin
                    if (take) begin
                        mode_q <= MODE_HANDLER;
                    end
                end
                MODE_HANDLER: begin
                    if (is_ret) begin
                        mode_q <= MODE_RUN;
                    end
                end
                default: mode_q <= MODE_RUN;
            endcase
        end
    end

    // The context is saved at entry and held on the restore outputs until the return.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            RST_ACC   <= '0;
            RST_X     <= '0;
            RST_FLAGS <= '0;
            RST_PC    <= '0;
        end else if (take) begin
            RST_ACC   <= CTX_ACC;
            RST_X     <= CTX_X;
            RST_FLAGS <= CTX_FLAGS;
            RST_PC    <= CTX_PC;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            IRQ_ENTER   <= 1'b0;
            ENTRY_PC    <= '0;
            IRQ_RESTORE <= 1'b0;
        end else begin
            IRQ_ENTER   <= take;
            IRQ_RESTORE <= ret_done;
            if (take) begin
                ENTRY_PC <= vec_rd;
            end
        end
    end

    assign ev = {|(flt_s2_q & ~fault_q), ret_done, take, ck_err, cmd.valid};

    // Reading the status clears it, but an event in that cycle survives.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            stat_q <= '0;
        end else if (REG_RD && REG_ADDR == REG_STAT) begin
            stat_q <= ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mask_q <= '0;
            node_q <= NODE_RST;
        end else if (REG_WR) begin
            if (REG_ADDR == REG_MASK) begin
                mask_q <= REG_WDATA[N_ST-1:0];
            end
            if (REG_ADDR == REG_NODE) begin
                node_q <= REG_WDATA[7:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= '0;
        end else begin
            REG_RDATA <= '0;
            if (REG_RD) begin
                case (REG_ADDR)
                    REG_STAT:  REG_RDATA <= DATA_W'(stat_q);
                    REG_MASK:  REG_RDATA <= DATA_W'(mask_q);
                    REG_FAULT: REG_RDATA <= DATA_W'(fault_q);
                    REG_CTRL:  REG_RDATA <= DATA_W'({mode_q == MODE_HANDLER, glob_en_q});
                    REG_SRCEN: REG_RDATA <= DATA_W'(src_en_q);
                    REG_NODE:  REG_RDATA <= DATA_W'(node_q);
                    default:   REG_RDATA <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            IRQ         <= 1'b0;
            FAULT_FLAGS <= '0;
        end else begin
            IRQ         <= |(stat_q & mask_q);
            FAULT_FLAGS <= fault_q;
        end
    end

    cle_all_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        is_cle && cmd.typ == TYP_ALL && flt_s2_q == '0 |=> fault_q == '0)
        else $error("Clear all left a fault flag set.");

    cle_one_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        is_cle && cmd.typ == TYP_TIMEOUT && !flt_s2_q[0]
        |=> !fault_q[0] && (fault_q[N_FLT-1:1] & $past(fault_q[N_FLT-1:1])) == $past(fault_q[N_FLT-1:1])
            && (fault_q[N_FLT-1:1] & ~$past(fault_q[N_FLT-1:1] | flt_s2_q[N_FLT-1:1])) == '0)
        else $error("Timeout clear hit the wrong flags.");

    en_one_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        is_en && src_ok(cmd.typ) |=> src_en_q[$past(cmd.typ[SRC_W-1:0])] && glob_en_q == $past(glob_en_q))
        else $error("Source enable did not take effect.");

    en_glob_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        is_en && cmd.typ == TYP_GLOBAL |=> glob_en_q && src_en_q == $past(src_en_q))
        else $error("Global enable not set or sources changed.");

    dis_one_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        is_dis && src_ok(cmd.typ) |=> !src_en_q[$past(cmd.typ[SRC_W-1:0])])
        else $error("Source disable did not take effect.");

    dis_glob_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        is_dis && cmd.typ == TYP_GLOBAL |=> !glob_en_q ##1 !IRQ_ENTER)
        else $error("Interrupt taken after global disable.");

    enter_pc_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        take |=> IRQ_ENTER && ENTRY_PC == $past(vec_rd) && mode_q == MODE_HANDLER)
        else $error("Entry address or mode wrong on interrupt entry.");

    ctx_save_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        take |=> RST_ACC == $past(CTX_ACC) && RST_X == $past(CTX_X)
            && RST_FLAGS == $past(CTX_FLAGS) && RST_PC == $past(CTX_PC))
        else $error("Context not saved on interrupt entry.");

    ret_back_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        ret_done |=> IRQ_RESTORE && mode_q == MODE_RUN && RST_PC == $past(RST_PC))
        else $error("Return did not restore the saved context.");
endmodule

/* File: verif/efic_host_model.sv */
// Purpose: Host side model that sends command frames to the unit.
// Assumes: One byte per clock, with at least one idle cycle between frames.
// Notes: Between frames the byte lines show the inverse of the last byte, so stale data is never read as valid.
module efic_host_model
    import efic_pkg::*;
(
    input  wire logic clk,
    output logic [7:0] rx_byte,
    output logic       rx_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
    end

    // A bad frame flips the low checksum bit, which is the smallest fault the receiver must catch.
    task automatic send(input logic [7:0] instr, input logic [7:0] typ, input logic [7:0] bank,
                        input logic [31:0] val, input bit bad);
        logic [7:0] f [9];
        logic [7:0] sum;
        f = '{NODE_RST, instr, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + f[i];
        end
        f[8] = bad ? (sum ^ 8'h01) : sum;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte  <= f[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte  <= ~f[8];
    endtask
endmodule

/* File: verif/tb_error_flag_and_interrupt_control.sv */
// Purpose: Self-checking bench for the fault flag and interrupt command unit.
// Assumes: Frames come from the host model; registers are reached over the plain port.
// Notes: Context inputs stay constant so saved and restored words are known in advance.
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_error_flag_and_interrupt_control;
    import efic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic              CLK_SYS = 1'b0;
    logic              RSTN    = 1'b0;
    logic [7:0]        RX_BYTE;
    logic              RX_VALID;
    logic [N_FLT-1:0]  FAULT_IN  = '0;
    logic [N_SRC-1:0]  IRQ_SRC   = '0;
    logic [DATA_W-1:0] CTX_ACC   = 32'hA5A50001;
    logic [DATA_W-1:0] CTX_X     = 32'h5A5A0002;
    logic [FLG_W-1:0]  CTX_FLAGS = 8'hC3;
    logic [DATA_W-1:0] CTX_PC    = 32'h00000077;
    logic [ADDR_W-1:0] REG_ADDR  = '0;
    logic [DATA_W-1:0] REG_WDATA = '0;
    logic              REG_WR    = 1'b0;
    logic              REG_RD    = 1'b0;
    logic [DATA_W-1:0] REG_RDATA, ENTRY_PC, RST_ACC, RST_X, RST_PC;
    logic [FLG_W-1:0]  RST_FLAGS;
    logic [N_FLT-1:0]  FAULT_FLAGS;
    logic              IRQ, IRQ_ENTER, IRQ_RESTORE;
    int                fail_count  = 0;
    int                check_count = 0;
    int                cyc_count   = 0;
    logic [DATA_W-1:0] rd;
    logic [N_FLT-1:0]  e;
    bit                seen;

    always #50 CLK_SYS = ~CLK_SYS;

    efic_host_model i_host (.clk(CLK_SYS), .rx_byte(RX_BYTE), .rx_valid(RX_VALID));

    efic_top i_dut (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .RX_BYTE(RX_BYTE), .RX_VALID(RX_VALID), .FAULT_IN(FAULT_IN),
        .IRQ_SRC(IRQ_SRC), .CTX_ACC(CTX_ACC), .CTX_X(CTX_X), .CTX_FLAGS(CTX_FLAGS), .CTX_PC(CTX_PC),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .IRQ(IRQ), .FAULT_FLAGS(FAULT_FLAGS), .IRQ_ENTER(IRQ_ENTER),
        .ENTRY_PC(ENTRY_PC), .IRQ_RESTORE(IRQ_RESTORE), .RST_ACC(RST_ACC), .RST_X(RST_X),
        .RST_FLAGS(RST_FLAGS), .RST_PC(RST_PC)
    );

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang would otherwise stall the run forever, so the cycle ceiling ends it as a failure.
    always @(posedge CLK_SYS) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge CLK_SYS);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge CLK_SYS);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask

    task automatic cmd(input logic [7:0] instr, input logic [7:0] typ, input logic [31:0] val);
        i_host.send(instr, typ, 8'h5A, val, 1'b0);
        cyc(5);
    endtask

    task automatic faults_up;
        @(posedge CLK_SYS);
        FAULT_IN <= '1;
        cyc(4);
        @(posedge CLK_SYS);
        FAULT_IN <= '0;
        cyc(5);
    endtask

    // Pulses are one cycle wide, so every cycle is looked at until a pulse is seen or the 40-cycle bound runs out.
    task automatic await(input bit restore, output bit hit);
        hit = 1'b0;
        for (int n = 0; n < 40; n++) begin
            @(posedge CLK_SYS);
            #1;
            if ((restore ? IRQ_RESTORE : IRQ_ENTER) === 1'b1) begin
                hit = 1'b1;
                break;
            end
        end
    endtask

    initial begin
        cyc(2);
        @(posedge CLK_SYS);
        RSTN <= 1'b1;
        reg_rd(REG_NODE, rd);
        `CHK("node", 32'h00000001, rd)
        reg_rd(4'hF, rd);
        `CHK("unmapped", 32'h00000000, rd)
        $display("test registers done");

        reg_wr(REG_MASK, 32'h00000010);
        faults_up();
        `CHK("irq", 1'b1, IRQ)
        reg_rd(REG_STAT, rd);
        `CHK("stat fault", 1'b1, rd[ST_FAULT])
        cyc(3);
        `CHK("irq cleared", 1'b0, IRQ)
        e = 5'h1F;
        for (int t = 1; t <= 5; t++) begin
            cmd(CMD_CLE, 8'(t), 32'hDEADBEEF);
            e[t-1] = 1'b0;
            `CHK("flags", e, FAULT_FLAGS)
        end
        faults_up();
        cmd(CMD_CLE, 8'h06, 32'h0);
        `CHK("flags", 5'h1F, FAULT_FLAGS)
        cmd(CMD_CLE, TYP_ALL, 32'hFFFFFFFF);
        `CHK("flags", 5'h00, FAULT_FLAGS)
        $display("test fault clear done");

        cmd(CMD_VEC_DEF, 8'h03, 32'h00000050);
        cmd(CMD_VEC_DEF, 8'h03, 32'h00000123);
        cmd(CMD_IRQ_EN, 8'h03, 32'h12345678);
        reg_rd(REG_SRCEN, rd);
        `CHK("srcen", 1'b1, rd[3])
        cmd(CMD_IRQ_EN, TYP_GLOBAL, 32'h0);
        reg_rd(REG_CTRL, rd);
        `CHK("global", 1'b1, rd[0])
        @(posedge CLK_SYS);
        IRQ_SRC[3] <= 1'b1;
        await(1'b0, seen);
        `CHK("enter", 1'b1, seen)
        `CHK("entry pc", 32'h00000123, ENTRY_PC)
        `CHK("saved acc", CTX_ACC, RST_ACC)
        `CHK("saved x", CTX_X, RST_X)
        `CHK("saved flags", CTX_FLAGS, RST_FLAGS)
        i_host.send(CMD_IRQ_RET, 8'hFF, 8'h00, 32'h0, 1'b0);
        await(1'b1, seen);
        `CHK("restore", 1'b1, seen)
        `CHK("saved pc", CTX_PC, RST_PC)
        cyc(3);
        reg_rd(REG_CTRL, rd);
        `CHK("in handler", 1'b0, rd[1])
        reg_rd(REG_STAT, rd);
        `CHK("stat events", 5'h1D, rd[N_ST-1:0])
        i_host.send(CMD_IRQ_RET, 8'hFF, 8'h00, 32'h0, 1'b0);
        await(1'b1, seen);
        `CHK("stray return", 1'b0, seen)
        $display("test vector and return done");

        cmd(CMD_IRQ_DIS, 8'h03, 32'h0);
        reg_rd(REG_SRCEN, rd);
        `CHK("srcen", 1'b0, rd[3])
        cmd(CMD_IRQ_EN, 8'h04, 32'h0);
        cmd(CMD_IRQ_DIS, TYP_GLOBAL, 32'h0);
        reg_rd(REG_CTRL, rd);
        `CHK("global", 1'b0, rd[0])
        @(posedge CLK_SYS);
        IRQ_SRC[4] <= 1'b1;
        await(1'b0, seen);
        `CHK("no enter", 1'b0, seen)
        $display("test disable done");

        i_host.send(CMD_IRQ_EN, 8'h05, 8'h00, 32'h0, 1'b1);
        cyc(5);
        reg_rd(REG_SRCEN, rd);
        `CHK("srcen bad", 1'b0, rd[5])
        reg_rd(REG_STAT, rd);
        `CHK("stat ckerr", 1'b1, rd[ST_CKERR])
        $display("test checksum done");
        wrap_up();
    end
endmodule
